// [design/scr_pkg.sv]
// How it works
// - crystal-wake-halving bit set: crystal wake period used is halved.
// - read-only ADC calibration done flag reads 1 once calibration finished.
// - fine-calibration enable set: RC oscillator fine calibration every 30 s.
// - force bit written 0 to 1 starts RC calibration; bit self-clears.
// - RC calibration runs automatically when wake-up timer or wake-on-receive starts.
// - VCO double-precision bit selects the longer VCO calibration measurement.
// - VCO force write of 1 in Idle with PLL on starts one calibration.
// - skip-VCO bit omits VCO calibration on the Idle to RX transition.
// - bit clock recovery compensation bypass bit disables its phase compensation.
// - slicer compensation bypass bit disables slicer phase compensation.
// - dither type: low adds +1/0, high adds plus or minus 1.
// - oscillation detection runs while its disable bit is low.
// - OOK threshold estimated from 8 preamble bits when set, else 4.
// - reference clock select: 1 picks 10 MHz clock, 0 the PLL clock.
// - reference clock inversion bit inverts the delta-sigma reference clock.
// - discriminator toggle bit cleared disables discriminator toggling.
// - charge pump force-up and force-down bits drive override outputs.
// - correction field reads what the pump uses; override drives written value.
// - charge pump correction value resets to all zeros.
// - 3-bit DC current field passed to the analog block statically.
package scr_pkg;

   localparam logic [6:0] ADDR_CAL_CTL   = 7'h55;
   localparam logic [6:0] ADDR_MODEM     = 7'h56;
   localparam logic [6:0] ADDR_PUMP_TEST = 7'h57;
   localparam logic [6:0] ADDR_PUMP_TRIM = 7'h58;
   localparam logic [6:0] ADDR_DIV_TRIM  = 7'h59;
   localparam logic [7:0] RD_UNMAPPED    = 8'h00;

   typedef struct packed {
      logic reserved;
      logic xtal_wake_half;
      logic adc_cal_done;
      logic rc_fine_en;
      logic rc_force;
      logic vco_double;
      logic vco_force;
      logic vco_skip;
   } scr_cal_s;

   typedef struct packed {
      logic bit_clock_recovery_byp;
      logic slicer_byp;
      logic dither_type;
      logic osc_det_off;
      logic ook_th8;
      logic ref_sel_10m;
      logic ref_inv;
      logic disc_toggle;
   } scr_modem_s;

   typedef struct packed {
      logic       pfd_reset;
      logic       fbdiv_reset;
      logic       force_up;
      logic       force_dn;
      logic       dc_only;
      logic [2:0] dc_current;
   } scr_pump_s;

   typedef struct packed {
      logic [1:0] gain;
      logic       corr_ov;
      logic [4:0] corr;
   } scr_trim_s;

   typedef struct packed {
      logic       reserved;
      logic       fbdiv_high_current;
      logic [1:0] div3_current_trim;
      logic [1:0] div2_current_trim;
      logic [1:0] div1p5_current_trim;
   } scr_div_s;

   localparam logic [7:0] CAL_RST   = 8'h44;
   localparam logic [7:0] MODEM_RST = 8'h00;
   localparam logic [7:0] PUMP_RST  = 8'h00;
   localparam logic [7:0] TRIM_RST  = 8'h80;
   localparam logic [7:0] DIV_RST   = 8'h80;

   localparam logic [1:0] DITH_PLUS  = 2'h1;
   localparam logic [1:0] DITH_ZERO  = 2'h0;
   localparam logic [1:0] DITH_MINUS = 2'h3;
   localparam logic [3:0] OOK_BITS_LONG  = 4'h8;
   localparam logic [3:0] OOK_BITS_SHORT = 4'h4;

   localparam longint CLK_HZ           = 100_000_000;
   localparam longint RC_CAL_TIME_US   = 2000;
   localparam longint FINE_PERIOD_S    = 30;
   localparam longint RC_CAL_CYC64     = RC_CAL_TIME_US * (CLK_HZ / 1_000_000);
   localparam longint FINE_CYC64       = FINE_PERIOD_S * CLK_HZ;
   localparam logic [31:0] RC_CAL_CYC  = RC_CAL_CYC64[31:0];
   localparam logic [31:0] FINE_CYC    = FINE_CYC64[31:0];
   localparam logic [15:0] XTAL_WAKE_CYC = 16'h0400;

endpackage

// [design/scr_cal_timer.sv]
`timescale 1ns/1ns
// one-shot down counter: done pulses load cycles after start
module scr_cal_timer #(
   parameter int CW = 32
) (
   input  wire logic          clk,     // system clock
   input  wire logic          rst_n,   // sync reset, low
   input  wire logic          ce,      // clock enable
   input  wire logic          start,   // begin a count
   input  wire logic          clr,     // abandon a count
   input  wire logic [CW-1:0] load,    // length in cycles
   output logic               busy,    // counting
   output logic               done     // end pulse
);

   logic [CW-1:0] cnt_reg;

   initial begin
      if (CW < 2 || CW > 32) $error("scr_cal_timer: CW out of range");
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (clr) begin
            busy <= 1'b0;
         end else if (start && !busy) begin
            cnt_reg <= load;
            busy    <= 1'b1;
         end else if (busy) begin
            if (cnt_reg <= CW'(1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - CW'(1);
            end
         end
      end
   end

endmodule // scr_cal_timer

// [design/scr_regs.sv]
`timescale 1ns/1ns
// calibration and test register bank behind the serial register port
module scr_regs #(
   parameter logic [31:0] RC_CAL_CYC = scr_pkg::RC_CAL_CYC,
   parameter logic [31:0] FINE_CYC   = scr_pkg::FINE_CYC,
   parameter logic [15:0] XTAL_CYC   = scr_pkg::XTAL_WAKE_CYC
) (
   input  wire logic               SYS_CLK,        // 100 MHz clock
   input  wire logic               RST_N,          // sync reset, low
   input  wire logic               CE,             // clock enable
   input  wire logic [6:0]         REG_ADDR,       // register address
   input  wire logic               REG_WR,         // write strobe
   input  wire logic               REG_RD,         // read strobe
   input  wire logic [7:0]         REG_WDATA,      // write data
   output logic [7:0]              REG_RDATA,      // read data
   input  wire logic               ADC_CAL_DONE,   // adc calibration finished
   input  wire logic               RC_OSC_EN,      // 32 kHz rc running
   input  wire logic               WUT_EN,         // wake-up timer enabled
   input  wire logic               WOR_STATE,      // wake-on-receive state
   output logic                    RC_CAL_START,   // rc calibration start pulse
   output logic                    RC_CAL_BUSY,    // rc calibration running
   input  wire logic               IDLE_STATE,     // device in idle
   input  wire logic               PLL_ON,         // pll-on setting
   input  wire logic               VCO_CAL_DONE,   // vco calibration finished
   output logic                    VCO_CAL_START,  // vco calibration start pulse
   output logic                    VCO_CAL_DOUBLE, // long measurement
   output logic                    VCO_CAL_SKIP,   // skip on idle to rx
   output logic [15:0]             XTAL_WAKE_CYC,  // crystal wake time used
   output scr_pkg::scr_modem_s     MODEM_CTL,      // modem test bits
   output logic                    BCR_COMP_EN,    // recovery phase comp on
   output logic                    SLICER_COMP_EN, // slicer phase comp on
   input  wire logic               DITHER_EN,      // dithering enabled
   input  wire logic               DITHER_RND,     // random dither bit
   output logic [1:0]              DITHER_VAL,     // dither added, two's compl
   output logic                    OSC_DET_EN,     // oscillation detect on
   output logic [3:0]              OOK_TH_BITS,    // preamble bits for threshold
   input  wire logic               REF_10M_IN,     // 10 MHz reference level
   input  wire logic               REF_PLL_IN,     // pll reference level
   output logic                    DSM_REF_CLK,    // selected reference
   output logic                    DISC_TOGGLE_EN, // discriminator toggling
   output scr_pkg::scr_pump_s      PUMP_CTL,       // charge pump test bits
   output logic                    CP_FORCE_UP,    // pump forced up
   output logic                    CP_FORCE_DN,    // pump forced down
   output logic [2:0]              CP_DC_CURRENT,  // pump dc current select
   input  wire logic [4:0]         CP_CORR_INT,    // internal pump correction
   output logic [4:0]              CP_CORR,        // correction seen by pump
   output logic [1:0]              CP_GAIN,        // pump gain
   output scr_pkg::scr_div_s       DIV_TRIM        // divider current trims
);

   ////////////////////////////////////////////////////////////////////////
   // stored registers

   scr_pkg::scr_cal_s   cal_reg;
   scr_pkg::scr_modem_s modem_reg;
   scr_pkg::scr_pump_s  pump_reg;
   scr_pkg::scr_trim_s  trim_reg;
   scr_pkg::scr_div_s   div_reg;
   scr_pkg::scr_cal_s   wcal;
   logic                rc_force_reg;
   logic                vco_force_reg;
   logic                wut_reg;
   logic                wor_reg;
   logic                wr_cal;
   logic                rc_req;
   logic                rc_auto;
   logic                rc_done;
   logic                fine_busy;
   logic                fine_done;
   logic                vco_req;
   logic [7:0]          rd_next;

   // reset image of the trim register, so its fields can be picked by name
   localparam scr_pkg::scr_trim_s TRIM_RST_S = scr_pkg::scr_trim_s'(scr_pkg::TRIM_RST);

   initial begin
      if (XTAL_CYC < 16'h0002) $error("scr_regs: XTAL_CYC too small");
      if (RC_CAL_CYC == 32'h0) $error("scr_regs: RC_CAL_CYC is zero");
      if (FINE_CYC == 32'h0) $error("scr_regs: FINE_CYC is zero");
   end

   assign wcal   = scr_pkg::scr_cal_s'(REG_WDATA);
   assign wr_cal = REG_WR && (REG_ADDR == scr_pkg::ADDR_CAL_CTL);

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         cal_reg   <= scr_pkg::scr_cal_s'(scr_pkg::CAL_RST);
         modem_reg <= scr_pkg::scr_modem_s'(scr_pkg::MODEM_RST);
         pump_reg  <= scr_pkg::scr_pump_s'(scr_pkg::PUMP_RST);
         trim_reg  <= scr_pkg::scr_trim_s'(scr_pkg::TRIM_RST);
         div_reg   <= scr_pkg::scr_div_s'(scr_pkg::DIV_RST);
      end else if (CE && REG_WR) begin
         case (REG_ADDR)
            scr_pkg::ADDR_CAL_CTL: begin
               cal_reg.xtal_wake_half <= wcal.xtal_wake_half;
               cal_reg.rc_fine_en     <= wcal.rc_fine_en;
               cal_reg.vco_double     <= wcal.vco_double;
               cal_reg.vco_skip       <= wcal.vco_skip;
            end
            scr_pkg::ADDR_MODEM:     modem_reg <= scr_pkg::scr_modem_s'(REG_WDATA);
            scr_pkg::ADDR_PUMP_TEST: pump_reg  <= scr_pkg::scr_pump_s'(REG_WDATA);
            scr_pkg::ADDR_PUMP_TRIM: trim_reg  <= scr_pkg::scr_trim_s'(REG_WDATA);
            scr_pkg::ADDR_DIV_TRIM:  div_reg   <= scr_pkg::scr_div_s'(REG_WDATA);
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // rc oscillator calibration

   // a request with the oscillator stopped is dropped, as nothing would run
   assign rc_req = wr_cal && wcal.rc_force && !rc_force_reg && RC_OSC_EN;

   assign rc_auto = RC_OSC_EN &&
                    ((WUT_EN && !wut_reg) || (WOR_STATE && !wor_reg) ||
                     fine_done);

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         wut_reg <= 1'b0;
         wor_reg <= 1'b0;
      end else if (CE) begin
         wut_reg <= WUT_EN;
         wor_reg <= WOR_STATE;
      end
   end

   // set wins over the completion clear
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         rc_force_reg <= 1'b0;
      end else if (CE) begin
         if (rc_req) begin
            rc_force_reg <= 1'b1;
         end else if (rc_done) begin
            rc_force_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         RC_CAL_START <= 1'b0;
      end else if (CE) begin
         RC_CAL_START <= (rc_req || rc_auto) && !RC_CAL_BUSY;
      end
   end

   scr_cal_timer #(
      .CW    (32)
   ) u_rc_cal (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .ce    (CE),
      .start (RC_CAL_START),
      .clr   (1'b0),
      .load  (RC_CAL_CYC),
      .busy  (RC_CAL_BUSY),
      .done  (rc_done)
   );

   // periodic fine calibration; disabling it drops the running period
   scr_cal_timer #(
      .CW    (32)
   ) u_fine (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .ce    (CE),
      .start (cal_reg.rc_fine_en && !fine_done),
      .clr   (!cal_reg.rc_fine_en),
      .load  (FINE_CYC),
      .busy  (fine_busy),
      .done  (fine_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // vco calibration

   assign vco_req = wr_cal && wcal.vco_force && !vco_force_reg &&
                    IDLE_STATE && PLL_ON;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         vco_force_reg <= 1'b0;
         VCO_CAL_START <= 1'b0;
      end else if (CE) begin
         VCO_CAL_START <= vco_req;
         if (vco_req) begin
            vco_force_reg <= 1'b1;
         end else if (VCO_CAL_DONE) begin
            vco_force_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // static and derived controls

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         VCO_CAL_DOUBLE <= 1'b0;
         VCO_CAL_SKIP   <= 1'b0;
         XTAL_WAKE_CYC  <= XTAL_CYC;
      end else if (CE) begin
         VCO_CAL_DOUBLE <= cal_reg.vco_double;
         VCO_CAL_SKIP   <= cal_reg.vco_skip;
         XTAL_WAKE_CYC  <= cal_reg.xtal_wake_half ? (XTAL_CYC >> 1) : XTAL_CYC;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         MODEM_CTL      <= scr_pkg::scr_modem_s'(scr_pkg::MODEM_RST);
         BCR_COMP_EN    <= 1'b1;
         SLICER_COMP_EN <= 1'b1;
         OSC_DET_EN     <= 1'b1;
         OOK_TH_BITS    <= scr_pkg::OOK_BITS_SHORT;
         DISC_TOGGLE_EN <= 1'b0;
      end else if (CE) begin
         MODEM_CTL      <= modem_reg;
         BCR_COMP_EN    <= !modem_reg.bit_clock_recovery_byp;
         SLICER_COMP_EN <= !modem_reg.slicer_byp;
         OSC_DET_EN     <= !modem_reg.osc_det_off;
         OOK_TH_BITS    <= modem_reg.ook_th8 ? scr_pkg::OOK_BITS_LONG
                                             : scr_pkg::OOK_BITS_SHORT;
         DISC_TOGGLE_EN <= modem_reg.disc_toggle;
      end
   end

   // dither value: +1/0 or +1/-1 picked by the random bit
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         DITHER_VAL <= scr_pkg::DITH_ZERO;
      end else if (CE) begin
         if (!DITHER_EN) begin
            DITHER_VAL <= scr_pkg::DITH_ZERO;
         end else if (DITHER_RND) begin
            DITHER_VAL <= scr_pkg::DITH_PLUS;
         end else if (modem_reg.dither_type) begin
            DITHER_VAL <= scr_pkg::DITH_MINUS;
         end else begin
            DITHER_VAL <= scr_pkg::DITH_ZERO;
         end
      end
   end

   // reference treated as a sampled level; one cycle of lag is accepted
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         DSM_REF_CLK <= 1'b0;
      end else if (CE) begin
         DSM_REF_CLK <= (modem_reg.ref_sel_10m ? REF_10M_IN : REF_PLL_IN)
                        ^ modem_reg.ref_inv;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         PUMP_CTL      <= scr_pkg::scr_pump_s'(scr_pkg::PUMP_RST);
         CP_FORCE_UP   <= 1'b0;
         CP_FORCE_DN   <= 1'b0;
         CP_DC_CURRENT <= '0;
         CP_CORR       <= '0;
         CP_GAIN       <= TRIM_RST_S.gain;
         DIV_TRIM      <= scr_pkg::scr_div_s'(scr_pkg::DIV_RST);
      end else if (CE) begin
         PUMP_CTL      <= pump_reg;
         CP_FORCE_UP   <= pump_reg.force_up;
         CP_FORCE_DN   <= pump_reg.force_dn;
         CP_DC_CURRENT <= pump_reg.dc_current;
         CP_CORR       <= trim_reg.corr_ov ? trim_reg.corr : CP_CORR_INT;
         CP_GAIN       <= trim_reg.gain;
         DIV_TRIM      <= div_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read back

   always_comb begin
      rd_next = scr_pkg::RD_UNMAPPED;
      case (REG_ADDR)
         scr_pkg::ADDR_CAL_CTL: begin
            rd_next = {1'b0,
                       cal_reg.xtal_wake_half,
                       ADC_CAL_DONE,
                       cal_reg.rc_fine_en,
                       rc_force_reg,
                       cal_reg.vco_double,
                       vco_force_reg,
                       cal_reg.vco_skip};
         end
         scr_pkg::ADDR_MODEM:     rd_next = modem_reg;
         scr_pkg::ADDR_PUMP_TEST: rd_next = pump_reg;
         scr_pkg::ADDR_PUMP_TRIM: begin
            rd_next = {trim_reg.gain, trim_reg.corr_ov, CP_CORR};
         end
         scr_pkg::ADDR_DIV_TRIM:  rd_next = div_reg;
         default:                 rd_next = scr_pkg::RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         REG_RDATA <= scr_pkg::RD_UNMAPPED;
      end else if (CE && REG_RD) begin
         REG_RDATA <= rd_next;
      end
   end

endmodule // scr_regs

// [sim/scr_regs_props.sv]
`timescale 1ns/1ns
module scr_regs_props #(
   parameter logic [31:0] RC_CAL_CYC = 32'h14
) (
   input wire logic               SYS_CLK,        // clock
   input wire logic               RST_N,          // sync reset, low
   input wire logic               CE,             // clock enable
   input wire logic [6:0]         REG_ADDR,       // address
   input wire logic               REG_WR,         // write strobe
   input wire logic [7:0]         REG_WDATA,      // write data
   input wire logic               IDLE_STATE,     // idle
   input wire logic               PLL_ON,         // pll on
   input wire logic               RC_CAL_START,   // rc start
   input wire logic               RC_CAL_BUSY,    // rc busy
   input wire logic               VCO_CAL_START,  // vco start
   input wire scr_pkg::scr_modem_s MODEM_CTL,     // modem bits
   input wire logic               BCR_COMP_EN,    // recovery comp
   input wire logic               SLICER_COMP_EN, // slicer comp
   input wire logic               OSC_DET_EN,     // osc detect
   input wire logic [3:0]         OOK_TH_BITS,    // ook bits
   input wire logic               DISC_TOGGLE_EN, // toggling
   input wire scr_pkg::scr_pump_s PUMP_CTL,       // pump bits
   input wire logic               CP_FORCE_UP,    // force up
   input wire logic               CP_FORCE_DN,    // force down
   input wire logic [2:0]         CP_DC_CURRENT   // dc current
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // last edge ran live, so a fall is real
   logic        pv_reg;
   logic [31:0] bcnt_reg;
   wire vco_req = REG_WR && CE && REG_ADDR == scr_pkg::ADDR_CAL_CTL && REG_WDATA[1];
   wire pump_wr = REG_WR && CE && REG_ADDR == scr_pkg::ADDR_PUMP_TEST;
   always_ff @(posedge SYS_CLK) pv_reg <= RST_N && CE;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) bcnt_reg <= '0;
      else if (CE) bcnt_reg <= RC_CAL_BUSY ? bcnt_reg + 32'h1 : '0;
   end
   sequence s_rc_go;
      RC_CAL_START ##1 RC_CAL_BUSY;
   endsequence
   sequence s_rc_end;
      pv_reg && $fell(RC_CAL_BUSY);
   endsequence
   AST_RC_GO: assert property (RC_CAL_START |-> s_rc_go)
      else $error("rc go");
   AST_RC_LEN: assert property (s_rc_end |-> bcnt_reg == RC_CAL_CYC)
      else $error("rc len");
   AST_VCO_GATE: assert property (
      VCO_CAL_START |-> $past(vco_req) && $past(IDLE_STATE) && $past(PLL_ON))
      else $error("vco gate");
   AST_PUMP_WR: assert property (pump_wr ##1 CE |-> ##1 PUMP_CTL == $past(REG_WDATA, 2))
      else $error("pump wr");
   AST_FORCE: assert property (
      CP_FORCE_UP == PUMP_CTL.force_up && CP_FORCE_DN == PUMP_CTL.force_dn)
      else $error("force");
   AST_DC_CUR: assert property (CP_DC_CURRENT == PUMP_CTL.dc_current)
      else $error("dc cur");
   AST_COMP: assert property (
      BCR_COMP_EN != MODEM_CTL.bit_clock_recovery_byp &&
      SLICER_COMP_EN != MODEM_CTL.slicer_byp)
      else $error("comp");
   AST_OSC: assert property (OSC_DET_EN != MODEM_CTL.osc_det_off)
      else $error("osc");
   AST_OOK: assert property (
      OOK_TH_BITS == (MODEM_CTL.ook_th8 ? scr_pkg::OOK_BITS_LONG : scr_pkg::OOK_BITS_SHORT))
      else $error("ook");
   AST_DISC: assert property (DISC_TOGGLE_EN == MODEM_CTL.disc_toggle)
      else $error("toggle");
endmodule // scr_regs_props
bind scr_regs scr_regs_props #(.RC_CAL_CYC(RC_CAL_CYC)) scr_regs_props_inst (.*);

// [sim/scr_host.sv]
`timescale 1ns/1ns
module scr_host (
   input  wire logic       clk,   // system clock
   output logic [6:0]      addr,  // register address
   output logic            wr,    // write strobe
   output logic            rd,    // read strobe
   output logic [7:0]      wdata, // write data
   input  wire logic [7:0] rdata  // read data
);
   initial {addr, wr, rd, wdata} = '0;
   // released lines show the inverse
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask
   // data stands until the next read
   task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      addr = ~a;
      @(posedge clk);
      #1;
      d = rdata;
   endtask
endmodule // scr_host

// [sim/scr_regs_tb.sv]
`timescale 1ns/1ns
module scr_regs_tb;
   logic SYS_CLK = 1'b0;
   logic RST_N, CE, REG_WR, REG_RD, ADC_CAL_DONE, RC_OSC_EN, WUT_EN, WOR_STATE, IDLE_STATE;
   logic PLL_ON, VCO_CAL_DONE, DITHER_EN, DITHER_RND, REF_10M_IN, REF_PLL_IN, RC_CAL_START;
   logic RC_CAL_BUSY, VCO_CAL_START, VCO_CAL_DOUBLE, VCO_CAL_SKIP, BCR_COMP_EN, DSM_REF_CLK;
   logic SLICER_COMP_EN, OSC_DET_EN, DISC_TOGGLE_EN, CP_FORCE_UP, CP_FORCE_DN;
   logic [6:0]  REG_ADDR;
   logic [7:0]  REG_WDATA, REG_RDATA;
   logic [15:0] XTAL_WAKE_CYC;
   logic [1:0]  DITHER_VAL, CP_GAIN;
   logic [3:0]  OOK_TH_BITS;
   logic [2:0]  CP_DC_CURRENT;
   logic [4:0]  CP_CORR_INT, CP_CORR;
   scr_pkg::scr_modem_s MODEM_CTL;
   scr_pkg::scr_pump_s  PUMP_CTL;
   scr_pkg::scr_div_s   DIV_TRIM;
   int fail_count = 0;
   int checks = 0;
   int rc_n = 0, vco_n = 0, blen = 0, last_len = 0;
   always #5 SYS_CLK = ~SYS_CLK;
   // short counts keep the run small; expectations use these figures
   scr_regs #(.RC_CAL_CYC(32'h14), .FINE_CYC(32'h32), .XTAL_CYC(16'h0080)) scr_regs_inst (.*);
   scr_host host_inst (.clk(SYS_CLK), .addr(REG_ADDR), .wr(REG_WR), .rd(REG_RD),
      .wdata(REG_WDATA), .rdata(REG_RDATA));
   // sampled mid-cycle, clear of the edge updates
   always @(negedge SYS_CLK) begin
      if (RC_CAL_START === 1'b1) rc_n++;
      if (VCO_CAL_START === 1'b1) vco_n++;
      if (RC_CAL_BUSY === 1'b1) blen++;
      else if (blen != 0) begin
         last_len = blen;
         blen = 0;
      end
   end
   ////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] d;
      host_inst.rd_reg(a, d);
      cmp($sformatf("reg %h", a), e, d);
   endtask
   task automatic settle;
      repeat (2) @(posedge SYS_CLK);
      #1;
   endtask
   task automatic wait_idle;
      settle;
      for (int k = 0; k < 200 && RC_CAL_BUSY !== 1'b0; k++) @(posedge SYS_CLK);
      settle;
   endtask
   ////////////////////////////////////////
   task automatic t_reset;
      logic [6:0] ra [6] = '{7'h55, 7'h56, 7'h57, 7'h58, 7'h59, 7'h5a};
      logic [7:0] re [6] = '{8'h64, 8'h00, 8'h00, 8'h8a, 8'h80, 8'h00};
      settle;
      cmp("xtal", 8'h40, XTAL_WAKE_CYC[7:0]);
      cmp("double", 8'h01, 8'(VCO_CAL_DOUBLE));
      rdc(scr_pkg::ADDR_CAL_CTL, 8'h44);
      ADC_CAL_DONE = 1'b1;
      for (int i = 0; i < 6; i++) rdc(ra[i], re[i]);
      host_inst.wr_reg(scr_pkg::ADDR_CAL_CTL, 8'ha1);
      settle;
      cmp("xtal", 8'h80, XTAL_WAKE_CYC[7:0]);
      cmp("double", 8'h00, 8'(VCO_CAL_DOUBLE));
      cmp("skip", 8'h01, 8'(VCO_CAL_SKIP));
      rdc(scr_pkg::ADDR_CAL_CTL, 8'h21);
   endtask
   task automatic t_modem;
      logic [7:0] v;
      for (int i = 0; i < 9; i++) begin
         v = (i == 8) ? 8'h26 : 8'h01 << i;
         host_inst.wr_reg(scr_pkg::ADDR_MODEM, v);
         settle;
         cmp("recov", 8'(!v[7]), 8'(BCR_COMP_EN));
         cmp("slicer", 8'(!v[6]), 8'(SLICER_COMP_EN));
         cmp("oscdet", 8'(!v[4]), 8'(OSC_DET_EN));
         cmp("ook", v[3] ? 8'h08 : 8'h04, 8'(OOK_TH_BITS));
         cmp("disc", 8'(v[0]), 8'(DISC_TOGGLE_EN));
         for (int r = 0; r < 4; r++) begin
            {DITHER_EN, DITHER_RND} = 2'(r);
            {REF_PLL_IN, REF_10M_IN} = 2'(r);
            @(posedge SYS_CLK);
            #1;
            cmp("dither", r[1] ? (r[0] ? 8'h01 : (v[5] ? 8'h03 : 8'h00)) : 8'h00,
               8'(DITHER_VAL));
            cmp("ref", 8'((v[2] ? r[0] : r[1]) ^ v[1]), 8'(DSM_REF_CLK));
         end
         rdc(scr_pkg::ADDR_MODEM, v);
      end
   endtask
   task automatic t_pump;
      logic [7:0] pv [2] = '{8'h35, 8'hca};
      foreach (pv[i]) begin
         host_inst.wr_reg(scr_pkg::ADDR_PUMP_TEST, pv[i]);
         settle;
         cmp("up", 8'(pv[i][5]), 8'(CP_FORCE_UP));
         cmp("dn", 8'(pv[i][4]), 8'(CP_FORCE_DN));
         cmp("dc", 8'(pv[i][2:0]), 8'(CP_DC_CURRENT));
         rdc(scr_pkg::ADDR_PUMP_TEST, pv[i]);
      end
      host_inst.wr_reg(scr_pkg::ADDR_PUMP_TRIM, 8'h75);
      settle;
      cmp("corr", 8'h15, 8'(CP_CORR));
      cmp("gain", 8'h01, 8'(CP_GAIN));
      rdc(scr_pkg::ADDR_PUMP_TRIM, 8'h75);
      host_inst.wr_reg(scr_pkg::ADDR_PUMP_TRIM, 8'h5f);
      settle;
      cmp("corr", 8'h0a, 8'(CP_CORR));
      rdc(scr_pkg::ADDR_PUMP_TRIM, 8'h4a);
      host_inst.wr_reg(scr_pkg::ADDR_DIV_TRIM, 8'h5b);
      settle;
      cmp("div", 8'h5b, DIV_TRIM);
      rdc(scr_pkg::ADDR_DIV_TRIM, 8'h5b);
   endtask
   task automatic t_rc;
      int n0;
      n0 = rc_n;
      host_inst.wr_reg(scr_pkg::ADDR_CAL_CTL, 8'h08);
      settle;
      cmp("rcstart", 8'(n0), 8'(rc_n));
      rdc(scr_pkg::ADDR_CAL_CTL, 8'h20);
      RC_OSC_EN = 1'b1;
      host_inst.wr_reg(scr_pkg::ADDR_CAL_CTL, 8'h08);
      rdc(scr_pkg::ADDR_CAL_CTL, 8'h28);
      cmp("rcstart", 8'(n0 + 1), 8'(rc_n));
      wait_idle;
      cmp("busylen", 8'h14, 8'(last_len));
      rdc(scr_pkg::ADDR_CAL_CTL, 8'h20);
      WUT_EN = 1'b1;
      wait_idle;
      cmp("rcstart", 8'(n0 + 2), 8'(rc_n));
      WOR_STATE = 1'b1;
      wait_idle;
      cmp("rcstart", 8'(n0 + 3), 8'(rc_n));
      host_inst.wr_reg(scr_pkg::ADDR_CAL_CTL, 8'h10);
      repeat (115) @(posedge SYS_CLK);
      #1;
      cmp("fine", 8'(n0 + 5), 8'(rc_n));
      host_inst.wr_reg(scr_pkg::ADDR_CAL_CTL, 8'h00);
      wait_idle;
   endtask
   task automatic t_vco;
      int n0;
      n0 = vco_n;
      PLL_ON = 1'b1;
      host_inst.wr_reg(scr_pkg::ADDR_CAL_CTL, 8'h02);
      settle;
      cmp("vcostart", 8'(n0), 8'(vco_n));
      rdc(scr_pkg::ADDR_CAL_CTL, 8'h20);
      IDLE_STATE = 1'b1;
      host_inst.wr_reg(scr_pkg::ADDR_CAL_CTL, 8'h02);
      settle;
      cmp("vcostart", 8'(n0 + 1), 8'(vco_n));
      rdc(scr_pkg::ADDR_CAL_CTL, 8'h22);
      VCO_CAL_DONE = 1'b1;
      @(posedge SYS_CLK);
      #1;
      VCO_CAL_DONE = 1'b0;
      settle;
      rdc(scr_pkg::ADDR_CAL_CTL, 8'h20);
   endtask
   ////////////////////////////////////////
   initial begin
      {RST_N, ADC_CAL_DONE, RC_OSC_EN, WUT_EN, WOR_STATE, IDLE_STATE, PLL_ON} = 7'h00;
      {VCO_CAL_DONE, DITHER_EN, DITHER_RND, REF_10M_IN, REF_PLL_IN} = 5'h00;
      CE = 1'b1;
      CP_CORR_INT = 5'h0a;
      repeat (8) @(posedge SYS_CLK);
      #1;
      RST_N = 1'b1;
      t_reset;
      t_modem;
      t_pump;
      t_rc;
      t_vco;
      summarize;
   end
   initial begin
      #100000;
      fail_count++;
      summarize;
   end
endmodule // scr_regs_tb
